// ### common/charger_limit_params.svh
`ifndef CHARGER_LIMIT_PARAMS_SVH
`define CHARGER_LIMIT_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define CSL_ADDR_SPECIAL          8'h05
`define CSL_ADDR_CEILING          8'h06

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
// The live status bits 4 and 3 are not stored, so they are zero here.
`define CSL_SPECIAL_RST           8'h24
`define CSL_CEILING_RST           8'h40

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CSL_REDUCED_BIT           5
`define CSL_LIMIT_STATUS_BIT      4
`define CSL_DISABLE_PIN_BIT       3
`define CSL_SPECIAL_CODE_MSB      2
`define CSL_SPECIAL_CODE_LSB      0
`define CSL_MAX_CHARGE_MSB        7
`define CSL_MAX_CHARGE_LSB        4
`define CSL_MAX_REG_MSB           3
`define CSL_MAX_REG_LSB           0

// ----------------------------------------------------------------------------
// Decode constants; voltages in mV, thresholds in units of 0.1 mV
// ----------------------------------------------------------------------------
`define CSL_SPECIAL_BASE_MV       13'h1068
`define CSL_SPECIAL_STEP_MV       13'h0050
`define CSL_CEIL_REG_BASE_MV      13'h1068
`define CSL_REG_STEP_MV           13'h0014
`define CSL_REG_BASE_MV           13'h0dac
`define CSL_CHARGE_BASE_DMV       11'h176
`define CSL_CHARGE_STEP_DMV       11'h044
`define CSL_REDUCED_CHARGE_DMV    11'h0dd
`define CSL_TERM_BASE_DMV         11'h022
`define CSL_TERM_STEP_DMV         11'h022

// ----------------------------------------------------------------------------
// Ceiling limits in code steps
// ----------------------------------------------------------------------------
`define CSL_MAX_REG_CODE_LIMIT    4'hc
`define CSL_MAX_CHARGE_CODE_LIMIT 4'ha
`define CSL_CEIL_IN_REG_CODE_BASE 6'h23

`endif

// ### common/charger_limit_pkg.sv
package charger_limit_pkg;

    typedef logic [7:0]  reg_byte_t;
    typedef logic [12:0] millivolt_t;
    typedef logic [10:0] tenth_mv_t;

    typedef enum logic {
        LIMITS_OPEN,
        LIMITS_LOCKED
    } limit_lock_e;

endpackage : charger_limit_pkg

// ### dv/charger_host_model.sv
`timescale 1ns/1ps
module charger_host_model (
    input  wire logic       clk_sys_i,
    input  wire logic [7:0] rdata_i,
    input  wire logic       rvalid_i,
    output logic            wr_o,
    output logic            rd_o,
    output logic      [7:0] addr_o,
    output logic      [7:0] wdata_o
);
    initial begin
        wr_o    = 1'b0;
        rd_o    = 1'b0;
        addr_o  = 8'h00;
        wdata_o = 8'h00;
    end

    // Released lines show the inverse, so stale values never pass for data.
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        wr_o    <= 1'b1;
        addr_o  <= a;
        wdata_o <= d;
        @(posedge clk_sys_i);
        wr_o    <= 1'b0;
        addr_o  <= ~a;
        wdata_o <= ~d;
    endtask : write

    task automatic read(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge clk_sys_i);
        rd_o   <= 1'b1;
        addr_o <= a;
        @(posedge clk_sys_i);
        rd_o   <= 1'b0;
        addr_o <= ~a;
        #1;
        v = rvalid_i;
        d = rdata_i;
    endtask : read
endmodule : charger_host_model

// ### dv/charger_safety_limit_regs_assertions.sv
`timescale 1ns/1ps
module charger_safety_limit_regs_checker (
    input wire logic       clk_sys_i,
    input wire logic       rst_b_i,
    input wire logic       safety_clear_n_i,
    input wire logic       sense_output_short_i,
    input wire logic       reg_wr_i,
    input wire logic       reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic       input_power_limiting_i,
    input wire logic       charge_disable_pin_i,
    input wire logic [5:0] regulation_code_req_i,
    input wire logic [3:0] fast_charge_code_req_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic       reg_rvalid_o,
    input wire logic       safety_locked_o,
    input wire logic [3:0] max_charge_current_code_o,
    input wire logic [3:0] max_regulation_voltage_code_o,
    input wire logic [5:0] regulation_code_o,
    input wire logic [3:0] fast_charge_code_o,
    input wire logic       fast_charge_clipped_o
);
    function automatic logic [3:0] lo4(input logic [3:0] a, input logic [3:0] b);
        return (a < b) ? a : b;
    endfunction : lo4
    function automatic logic [5:0] lo6(input logic [5:0] a, input logic [5:0] b);
        return (a < b) ? a : b;
    endfunction : lo6

    wire logic [7:0] ceiling_byte = {max_charge_current_code_o, max_regulation_voltage_code_o};
    logic      [3:0] fast_cap_q;
    logic      [5:0] reg_cap_q;

    // Caps lag the ceiling by one cycle, as the clamp does.
    always_ff @(posedge clk_sys_i) begin
        fast_cap_q <= lo4(max_charge_current_code_o, 4'ha);
        reg_cap_q  <= 6'h23 + 6'(lo4(max_regulation_voltage_code_o, 4'hc));
    end

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_b_i);

    sequence s_wr_other;
        reg_wr_i && reg_addr_i != 8'h06;
    endsequence
    sequence s_wr_ceiling;
        reg_wr_i && reg_addr_i == 8'h06 && !safety_locked_o && safety_clear_n_i
            && !sense_output_short_i;
    endsequence
    sequence s_read_answer;
        reg_rvalid_o ##1 reg_rvalid_o == $past(reg_rd_i);
    endsequence

    property p_read_answer;
        reg_rd_i |=> s_read_answer;
    endproperty
    property p_status_bits;
        reg_rd_i && reg_addr_i == 8'h05 |=> reg_rdata_o[4:3] ==
            {$past(input_power_limiting_i), $past(charge_disable_pin_i)};
    endproperty
    property p_lock_on_other;
        s_wr_other |=> safety_locked_o || !safety_clear_n_i;
    endproperty
    property p_ceiling_write;
        s_wr_ceiling |=> ceiling_byte == $past(reg_wdata_i) || !safety_clear_n_i;
    endproperty
    property p_locked_hold;
        safety_locked_o && !sense_output_short_i |=> $stable(ceiling_byte) || !safety_clear_n_i;
    endproperty
    property p_short_clear;
        sense_output_short_i && !reg_wr_i |=> ceiling_byte == 8'h40 && !safety_locked_o;
    endproperty
    property p_fast_clamp;
        rst_b_i |=> fast_charge_code_o == lo4($past(fast_charge_code_req_i), fast_cap_q)
            && fast_charge_clipped_o == ($past(fast_charge_code_req_i) > fast_cap_q);
    endproperty
    property p_reg_clamp;
        rst_b_i |=> regulation_code_o == lo6($past(regulation_code_req_i), reg_cap_q);
    endproperty

    a_read_answer: assert property (p_read_answer) else $error("read answer wrong");
    a_status_bits: assert property (p_status_bits) else $error("status bits wrong");
    a_lock_on_other: assert property (p_lock_on_other) else $error("no lock");
    a_ceiling_write: assert property (p_ceiling_write) else $error("ceiling lost");
    a_locked_hold: assert property (p_locked_hold) else $error("locked ceiling moved");
    a_short_clear: assert property (p_short_clear) else $error("short clear wrong");
    a_fast_clamp: assert property (p_fast_clamp) else $error("fast clamp wrong");
    a_reg_clamp: assert property (p_reg_clamp) else $error("regulation clamp wrong");
endmodule : charger_safety_limit_regs_checker

bind charger_safety_limit_regs charger_safety_limit_regs_checker i_chk (.*);

// ### dv/charger_safety_limit_regs_tb.sv
`timescale 1ns/1ps
module charger_safety_limit_regs_tb;
    logic                          clk_sys_i, rst_b_i, safety_clear_n_i, sense_output_short_i;
    logic                          input_power_limiting_i, charge_disable_pin_i;
    logic                          reg_wr_i, reg_rd_i, reg_rvalid_o, safety_locked_o;
    logic                          reduced_charge_select_o, regulation_clipped_o;
    logic                          fast_charge_clipped_o, rd_ok;
    logic [7:0]                    reg_addr_i, reg_wdata_i, reg_rdata_o, rd_byte;
    logic [2:0]                    special_source_voltage_code_o, termination_threshold_code_i;
    logic [3:0]                    max_charge_current_code_o, max_regulation_voltage_code_o;
    logic [3:0]                    fast_charge_code_o, fast_charge_code_req_i;
    logic [5:0]                    regulation_code_o, regulation_code_req_i;
    charger_limit_pkg::millivolt_t special_source_voltage_mv_o, max_regulation_voltage_mv_o;
    charger_limit_pkg::millivolt_t regulation_voltage_mv_o;
    charger_limit_pkg::tenth_mv_t  max_charge_threshold_dmv_o, charge_threshold_dmv_o;
    charger_limit_pkg::tenth_mv_t  termination_threshold_dmv_o;
    int                            mismatches, check_count;

    charger_safety_limit_regs i_dut (.*);

    charger_host_model i_host (
        .clk_sys_i, .rdata_i(reg_rdata_o), .rvalid_i(reg_rvalid_o), .wr_o(reg_wr_i),
        .rd_o(reg_rd_i), .addr_o(reg_addr_i), .wdata_o(reg_wdata_i)
    );

    initial begin
        clk_sys_i = 1'b0;
        forever #10 clk_sys_i = ~clk_sys_i;
    end

    task automatic check_value(input logic [12:0] got, input logic [12:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_value

    task automatic settle;
        repeat (2) @(posedge clk_sys_i);
        #1;
    endtask : settle

    task automatic t_defaults;
        i_host.read(8'h06, rd_byte, rd_ok);
        check_value(rd_byte, 8'h40);
        check_value(rd_ok, 1'b1);
        i_host.read(8'h05, rd_byte, rd_ok);
        check_value(rd_byte, 8'h34);
        check_value(special_source_voltage_mv_o, 13'd4520);
        check_value(max_charge_threshold_dmv_o, 11'd646);
        check_value(max_regulation_voltage_mv_o, 13'd4200);
        check_value(charge_threshold_dmv_o, 11'd221);
        $display("t_defaults done");
    endtask : t_defaults

    task automatic t_ceiling;
        i_host.write(8'h06, 8'hff);
        i_host.read(8'h06, rd_byte, rd_ok);
        check_value(rd_byte, 8'hff);
        check_value(max_charge_threshold_dmv_o, 11'd1054);
        check_value(max_regulation_voltage_mv_o, 13'd4440);
        i_host.write(8'h06, 8'h31);
        @(posedge clk_sys_i);
        regulation_code_req_i  <= 6'h3f;
        fast_charge_code_req_i <= 4'hf;
        settle;
        check_value(regulation_code_o, 6'd36);
        check_value(regulation_clipped_o, 1'b1);
        check_value(fast_charge_code_o, 4'd3);
        check_value(fast_charge_clipped_o, 1'b1);
        check_value(regulation_voltage_mv_o, 13'd4220);
        check_value(safety_locked_o, 1'b0);
        i_host.write(8'h02, 8'h00);
        i_host.write(8'h06, 8'hff);
        i_host.read(8'h06, rd_byte, rd_ok);
        check_value(rd_byte, 8'h31);
        check_value(safety_locked_o, 1'b1);
        $display("t_ceiling done");
    endtask : t_ceiling

    task automatic t_special;
        i_host.write(8'h05, 8'hd2);
        @(posedge clk_sys_i);
        input_power_limiting_i <= 1'b0;
        charge_disable_pin_i   <= 1'b1;
        fast_charge_code_req_i <= 4'h2;
        settle;
        i_host.read(8'h05, rd_byte, rd_ok);
        check_value(rd_byte, 8'hca);
        check_value(special_source_voltage_code_o, 3'h2);
        check_value(reduced_charge_select_o, 1'b0);
        check_value(charge_threshold_dmv_o, 11'd510);
        check_value(special_source_voltage_mv_o, 13'd4360);
        for (int c = 0; c < 8; c++) begin
            @(posedge clk_sys_i);
            termination_threshold_code_i <= c[2:0];
            settle;
            check_value(termination_threshold_dmv_o, 13'(34 + 34 * c));
        end
        $display("t_special done");
    endtask : t_special

    task automatic t_clear;
        @(posedge clk_sys_i);
        sense_output_short_i <= 1'b1;
        @(posedge clk_sys_i);
        sense_output_short_i <= 1'b0;
        #1;
        check_value({max_charge_current_code_o, max_regulation_voltage_code_o}, 8'h40);
        check_value(safety_locked_o, 1'b0);
        i_host.write(8'h06, 8'h5a);
        @(posedge clk_sys_i);
        rst_b_i <= 1'b0;
        @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        i_host.read(8'h06, rd_byte, rd_ok);
        check_value(rd_byte, 8'h5a);
        @(posedge clk_sys_i);
        safety_clear_n_i <= 1'b0;
        @(posedge clk_sys_i);
        safety_clear_n_i <= 1'b1;
        #1;
        check_value(safety_locked_o, 1'b0);
        i_host.write(8'h04, 8'h01);
        i_host.write(8'h06, 8'hff);
        i_host.read(8'h06, rd_byte, rd_ok);
        check_value(rd_byte, 8'h40);
        $display("t_clear done");
    endtask : t_clear

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        rst_b_i                      = 1'b0;
        safety_clear_n_i             = 1'b0;
        sense_output_short_i         = 1'b0;
        input_power_limiting_i       = 1'b1;
        charge_disable_pin_i         = 1'b0;
        regulation_code_req_i        = 6'h00;
        fast_charge_code_req_i       = 4'h0;
        termination_threshold_code_i = 3'h0;
        repeat (3) @(posedge clk_sys_i);
        rst_b_i          <= 1'b1;
        safety_clear_n_i <= 1'b1;
        t_defaults;
        t_ceiling;
        t_special;
        t_clear;
        tally_and_finish;
    end

    // The tests need under a thousand cycles.
    initial begin
        #100_000;
        mismatches++;
        tally_and_finish;
    end
endmodule : charger_safety_limit_regs_tb

// ### verilog/ceiling_clamp.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Passes the requested code unless it is above the ceiling
// ----------------------------------------------------------------------------
module ceiling_clamp #(
    parameter int W = 4
) (
    input  wire logic [W-1:0] request_i,
    input  wire logic [W-1:0] ceiling_i,
    output logic      [W-1:0] granted_o,
    output logic              clipped_o
);

    assign clipped_o = (request_i > ceiling_i);
    assign granted_o = clipped_o ? ceiling_i : request_i;

endmodule : ceiling_clamp

// ### verilog/charger_safety_limit_regs.sv
`timescale 1ns/1ps
`include "charger_limit_params.svh"

// Overview of operation
// - Reduced-charge select bit picks 22.1 mV or the fast-charge code; resets to one.
// - Register 05 bit 4 reads input power limiting state; writes ignored.
// - Register 05 bit 3 reads the charge-disable pin level.
// - Register 05 bits 2..0 are a writable voltage code, reset 100.
// - Special source voltage is 4.2 V plus 80 mV per step; reset 4.52 V.
// - Register 06 bits 7..4 hold maximum charge current code, reset 0100.
// - Maximum charge threshold is 37.4 mV plus code; reset 64.6, top 105.4.
// - Register 06 bits 3..0 hold maximum regulation voltage code, reset zero.
// - Maximum regulation voltage is 4.2 V plus code, top 4.44 V.
// - Register 06 resets only on sense short or the low safety clear pin.
// - Register 06 is writable until any other register is written.
// - Regulation and fast-charge codes are limited to the register 06 ceilings.
// - Host writes register 06 first, else the default ceilings are locked.
// - Termination threshold is 3.4 mV plus 3.4 mV per code step.
// - Fast-charge threshold is 37.4 mV plus 6.8 mV per code step.
// - Regulation code decodes as 3.5 V plus 20 mV per step.
module charger_safety_limit_regs (
    input  wire logic                          clk_sys_i,
    input  wire logic                          rst_b_i,
    input  wire logic                          safety_clear_n_i,
    input  wire logic                          sense_output_short_i,
    input  wire logic                          reg_wr_i,
    input  wire logic                          reg_rd_i,
    input  wire logic [7:0]                    reg_addr_i,
    input  wire logic [7:0]                    reg_wdata_i,
    input  wire logic                          input_power_limiting_i,
    input  wire logic                          charge_disable_pin_i,
    input  wire logic [5:0]                    regulation_code_req_i,
    input  wire logic [3:0]                    fast_charge_code_req_i,
    input  wire logic [2:0]                    termination_threshold_code_i,
    output logic      [7:0]                    reg_rdata_o,
    output logic                               reg_rvalid_o,
    output logic                               safety_locked_o,
    output logic                               reduced_charge_select_o,
    output logic      [2:0]                    special_source_voltage_code_o,
    output logic      [3:0]                    max_charge_current_code_o,
    output logic      [3:0]                    max_regulation_voltage_code_o,
    output logic      [5:0]                    regulation_code_o,
    output logic      [3:0]                    fast_charge_code_o,
    output logic                               regulation_clipped_o,
    output logic                               fast_charge_clipped_o,
    output charger_limit_pkg::millivolt_t      special_source_voltage_mv_o,
    output charger_limit_pkg::millivolt_t      max_regulation_voltage_mv_o,
    output charger_limit_pkg::millivolt_t      regulation_voltage_mv_o,
    output charger_limit_pkg::tenth_mv_t       max_charge_threshold_dmv_o,
    output charger_limit_pkg::tenth_mv_t       charge_threshold_dmv_o,
    output charger_limit_pkg::tenth_mv_t       termination_threshold_dmv_o
);

    // ------------------------------------------------------------------------
    // Register storage and write decode
    // ------------------------------------------------------------------------
    charger_limit_pkg::reg_byte_t   special_reg;
    charger_limit_pkg::reg_byte_t   ceiling_reg;
    charger_limit_pkg::limit_lock_e lock_state;

    logic wr_special;
    logic wr_ceiling;
    logic wr_other;

    assign wr_special = reg_wr_i && (reg_addr_i == `CSL_ADDR_SPECIAL);
    assign wr_ceiling = reg_wr_i && (reg_addr_i == `CSL_ADDR_CEILING);
    assign wr_other   = reg_wr_i && (reg_addr_i != `CSL_ADDR_CEILING);

    // The general reset loads the reset value into this byte; status bits are never stored.
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            special_reg <= `CSL_SPECIAL_RST;
        end else if (wr_special) begin
            special_reg <= reg_wdata_i & ~((8'h01 << `CSL_LIMIT_STATUS_BIT)
                                          | (8'h01 << `CSL_DISABLE_PIN_BIT));
        end
    end

    // ------------------------------------------------------------------------
    // Safety ceiling register
    // ------------------------------------------------------------------------
    // Only the clear pin and a shorted sense output reach this byte; the
    // general reset deliberately does not, so a processor reset cannot reopen
    // the ceilings. At power up the clear pin or the short must be seen once.
    always_ff @(posedge clk_sys_i or negedge safety_clear_n_i) begin
        if (!safety_clear_n_i) begin
            ceiling_reg <= `CSL_CEILING_RST;
        end else if (sense_output_short_i) begin
            ceiling_reg <= `CSL_CEILING_RST;
        end else if (wr_ceiling && (lock_state == charger_limit_pkg::LIMITS_OPEN)) begin
            ceiling_reg <= reg_wdata_i;
        end
    end

    // A write elsewhere in the same cycle as a short still locks: the set
    // wins, and the ceilings it locks are the defaults loaded by the short.
    always_ff @(posedge clk_sys_i or negedge safety_clear_n_i) begin
        if (!safety_clear_n_i) begin
            lock_state <= charger_limit_pkg::LIMITS_OPEN;
        end else begin
            case (lock_state)
                charger_limit_pkg::LIMITS_OPEN: begin
                    if (wr_other) begin
                        lock_state <= charger_limit_pkg::LIMITS_LOCKED;
                    end
                end
                charger_limit_pkg::LIMITS_LOCKED: begin
                    if (sense_output_short_i && !wr_other) begin
                        lock_state <= charger_limit_pkg::LIMITS_OPEN;
                    end
                end
                default: begin
                    lock_state <= charger_limit_pkg::LIMITS_LOCKED;
                end
            endcase
        end
    end

    assign safety_locked_o = (lock_state == charger_limit_pkg::LIMITS_LOCKED);

    // ------------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------------
    // Status bits are sampled in the read cycle itself, so a read shows the
    // pin and the limiting state as they stood one edge before rvalid.
    charger_limit_pkg::reg_byte_t next_rdata;

    always_comb begin
        next_rdata = 8'h00;
        if (reg_addr_i == `CSL_ADDR_SPECIAL) begin
            next_rdata                        = special_reg;
            next_rdata[`CSL_LIMIT_STATUS_BIT] = input_power_limiting_i;
            next_rdata[`CSL_DISABLE_PIN_BIT]  = charge_disable_pin_i;
        end else if (reg_addr_i == `CSL_ADDR_CEILING) begin
            next_rdata = ceiling_reg;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            reg_rdata_o  <= 8'h00;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i) begin
                reg_rdata_o <= next_rdata;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Field views
    // ------------------------------------------------------------------------
    logic [2:0] special_code;
    logic [3:0] max_charge_code;
    logic [3:0] max_reg_code;

    assign special_code    = special_reg[`CSL_SPECIAL_CODE_MSB:`CSL_SPECIAL_CODE_LSB];
    assign max_charge_code = ceiling_reg[`CSL_MAX_CHARGE_MSB:`CSL_MAX_CHARGE_LSB];
    assign max_reg_code    = ceiling_reg[`CSL_MAX_REG_MSB:`CSL_MAX_REG_LSB];

    assign reduced_charge_select_o       = special_reg[`CSL_REDUCED_BIT];
    assign special_source_voltage_code_o = special_code;
    assign max_charge_current_code_o     = max_charge_code;
    assign max_regulation_voltage_code_o = max_reg_code;

    // ------------------------------------------------------------------------
    // Ceiling saturation and limiting
    // ------------------------------------------------------------------------
    // Codes above the largest selectable ceiling behave as the largest one.
    logic [3:0] sat_max_charge;
    logic [3:0] sat_max_reg;
    logic [5:0] ceil_in_reg_code;
    logic [5:0] next_regulation_code;
    logic [3:0] next_fast_code;
    logic       next_reg_clip;
    logic       next_fast_clip;

    ceiling_clamp #(.W(4)) u_sat_charge (
        .request_i (max_charge_code),
        .ceiling_i (`CSL_MAX_CHARGE_CODE_LIMIT),
        .granted_o (sat_max_charge),
        .clipped_o ()
    );

    ceiling_clamp #(.W(4)) u_sat_reg (
        .request_i (max_reg_code),
        .ceiling_i (`CSL_MAX_REG_CODE_LIMIT),
        .granted_o (sat_max_reg),
        .clipped_o ()
    );

    // The ceiling starts 700 mV above the regulation base, 35 steps of 20 mV.
    assign ceil_in_reg_code = `CSL_CEIL_IN_REG_CODE_BASE + {2'b00, sat_max_reg};

    ceiling_clamp #(.W(6)) u_clamp_reg (
        .request_i (regulation_code_req_i),
        .ceiling_i (ceil_in_reg_code),
        .granted_o (next_regulation_code),
        .clipped_o (next_reg_clip)
    );

    // Fast-charge and ceiling codes share base and weights, so codes compare.
    ceiling_clamp #(.W(4)) u_clamp_fast (
        .request_i (fast_charge_code_req_i),
        .ceiling_i (sat_max_charge),
        .granted_o (next_fast_code),
        .clipped_o (next_fast_clip)
    );

    // ------------------------------------------------------------------------
    // Decoders
    // ------------------------------------------------------------------------
    charger_limit_pkg::millivolt_t next_special_mv;
    charger_limit_pkg::millivolt_t next_max_reg_mv;
    charger_limit_pkg::millivolt_t next_reg_mv;
    charger_limit_pkg::tenth_mv_t  next_max_charge_dmv;
    charger_limit_pkg::tenth_mv_t  next_fast_dmv;
    charger_limit_pkg::tenth_mv_t  next_charge_dmv;
    charger_limit_pkg::tenth_mv_t  next_term_dmv;

    linear_decode #(
        .CODE_W (3),
        .OUT_W  (13),
        .BASE   (`CSL_SPECIAL_BASE_MV),
        .STEP   (`CSL_SPECIAL_STEP_MV)
    ) u_dec_special (
        .code_i  (special_code),
        .value_o (next_special_mv)
    );

    linear_decode #(
        .CODE_W (4),
        .OUT_W  (13),
        .BASE   (`CSL_CEIL_REG_BASE_MV),
        .STEP   (`CSL_REG_STEP_MV)
    ) u_dec_max_reg (
        .code_i  (sat_max_reg),
        .value_o (next_max_reg_mv)
    );

    linear_decode #(
        .CODE_W (6),
        .OUT_W  (13),
        .BASE   (`CSL_REG_BASE_MV),
        .STEP   (`CSL_REG_STEP_MV)
    ) u_dec_reg (
        .code_i  (next_regulation_code),
        .value_o (next_reg_mv)
    );

    linear_decode #(
        .CODE_W (4),
        .OUT_W  (11),
        .BASE   (`CSL_CHARGE_BASE_DMV),
        .STEP   (`CSL_CHARGE_STEP_DMV)
    ) u_dec_max_charge (
        .code_i  (sat_max_charge),
        .value_o (next_max_charge_dmv)
    );

    linear_decode #(
        .CODE_W (4),
        .OUT_W  (11),
        .BASE   (`CSL_CHARGE_BASE_DMV),
        .STEP   (`CSL_CHARGE_STEP_DMV)
    ) u_dec_fast (
        .code_i  (next_fast_code),
        .value_o (next_fast_dmv)
    );

    linear_decode #(
        .CODE_W (3),
        .OUT_W  (11),
        .BASE   (`CSL_TERM_BASE_DMV),
        .STEP   (`CSL_TERM_STEP_DMV)
    ) u_dec_term (
        .code_i  (termination_threshold_code_i),
        .value_o (next_term_dmv)
    );

    // The reduced level bypasses the ceiling: it is always below the lowest one.
    assign next_charge_dmv = reduced_charge_select_o ? `CSL_REDUCED_CHARGE_DMV
                                                     : next_fast_dmv;

    // ------------------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------------------
    // One cycle of latency keeps every analog-facing value glitch free.
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            regulation_code_o           <= 6'h00;
            fast_charge_code_o          <= 4'h0;
            regulation_clipped_o        <= 1'b0;
            fast_charge_clipped_o       <= 1'b0;
            special_source_voltage_mv_o <= 13'h0000;
            max_regulation_voltage_mv_o <= 13'h0000;
            regulation_voltage_mv_o     <= 13'h0000;
            max_charge_threshold_dmv_o  <= 11'h000;
            charge_threshold_dmv_o      <= 11'h000;
            termination_threshold_dmv_o <= 11'h000;
        end else begin
            regulation_code_o           <= next_regulation_code;
            fast_charge_code_o          <= next_fast_code;
            regulation_clipped_o        <= next_reg_clip;
            fast_charge_clipped_o       <= next_fast_clip;
            special_source_voltage_mv_o <= next_special_mv;
            max_regulation_voltage_mv_o <= next_max_reg_mv;
            regulation_voltage_mv_o     <= next_reg_mv;
            max_charge_threshold_dmv_o  <= next_max_charge_dmv;
            charge_threshold_dmv_o      <= next_charge_dmv;
            termination_threshold_dmv_o <= next_term_dmv;
        end
    end

endmodule : charger_safety_limit_regs

// ### verilog/linear_decode.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Binary-weighted code to physical value: base plus code times the LSB step
// ----------------------------------------------------------------------------
module linear_decode #(
    parameter int CODE_W = 4,
    parameter int OUT_W  = 11,
    parameter int BASE   = 0,
    parameter int STEP   = 1
) (
    input  wire logic [CODE_W-1:0] code_i,
    output logic      [OUT_W-1:0]  value_o
);

    logic [31:0] full;

    // Every weight is twice the next one, so a single step times the code covers it.
    assign full    = 32'(BASE) + 32'(code_i) * 32'(STEP);
    assign value_o = full[OUT_W-1:0];

endmodule : linear_decode
